// [rsa_addressing.sv]
// Functional notes
// RULE1: Sub-sampling code 000/001/010/011/1xx gives pixel steps 2/4/6/8/12.
// RULE2: Every mode reads two adjacent pixels per group; only the skip changes.
// RULE3: Addressing pattern repeats in blocks 24 pixels wide.
// RULE4: Column start takes 99 coordinates, row start takes 138.
// RULE5: Columns are always selected two at a time, odd and even together.
// RULE6: Rows are selected individually, one at a time.
// RULE7: Two independent row pointers: one reading, one resetting.
// RULE8: Each row clock advances both read and reset pointers by one.
// RULE9: Exposure equals pointer separation, programmed in lines.
// RULE10: Both-side bit or readout modes 1/2 merge row registers, drive both sides.
// RULE11: Lines are read and reset strictly in sequence, equal exposure each.
// RULE12: Reset pointer leads read pointer by programmed lines, wrapping in frame.
// RULE13: Column sub-sampling code sits in bits 4:2 of core configuration.
// RULE14: Controller issues frame-start pulse that initialises the row sequence.
// RULE15: Controller issues row clock per row, which loads the column register.
// RULE16: Both-side bit: 0 selects electronic shutter, 1 both-side addressing.
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module rsa_addressing #(
    parameter int ROW_W = 12,
    parameter int COL_W = 12
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Timing controller pulses
    input  wire logic              frame_start,
    input  wire logic              row_clk,
    input  wire logic              pix_en,
    // Row addressing
    output rsa_pkg::rsa_row_s      row_addr,
    output logic                   row_read_pulse,
    output logic                   row_reset_pulse,
    output logic                   both_sides,
    // Column addressing
    output logic [COL_W-1:0]       col_pair_addr,
    output logic                   col_valid
);

    if (ROW_W < 12 || COL_W < 12) begin : g_bad_width
        $error("rsa_addressing: ROW_W and COL_W must be at least 12");
    end

    // Pixel step for a sub-sampling code
    function automatic logic [3:0] step_of(input logic [2:0] code);
        logic [3:0] s;
        s = rsa_pkg::STEP_E;
        if (code == 3'h0) s = rsa_pkg::STEP_A;
        else if (code == 3'h1) s = rsa_pkg::STEP_B;
        else if (code == 3'h2) s = rsa_pkg::STEP_C;
        else if (code == 3'h3) s = rsa_pkg::STEP_D;
        return s; // RULE1
    endfunction : step_of

    // Row address of a line index: pairs of adjacent rows, then skip
    function automatic logic [15:0] row_of(input logic [7:0] start, input logic [11:0] idx,
                                           input logic [3:0] step);
        logic [15:0] base;
        base = 16'(start) * 16'(rsa_pkg::BLOCK_W); // RULE3
        return 16'(base + 16'(idx[11:1]) * 16'(step) + 16'(idx[0])); // RULE2 RULE6
    endfunction : row_of

    // Byte-strobe merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    // Registers
    logic [2:0]  col_sub_q;
    logic [11:0] seq_cfg_q;
    logic [11:0] int_lines_q;
    logic [6:0]  x_start_q;
    logic [7:0]  y_start_q;
    logic [11:0] num_lines_q;
    logic [10:0] num_pairs_q;

    // Bus state
    logic        aw_have_q;
    logic        w_have_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    wire         aw_take = s_axi_awvalid && s_axi_awready;
    wire         w_take  = s_axi_wvalid && s_axi_wready;
    wire         ar_take = s_axi_arvalid && s_axi_arready;
    wire         wr_go   = aw_have_q && w_have_q && !bvalid_q;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready  = !w_have_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    // Write decode
    wire wr_core  = wr_go && aw_addr_q == rsa_pkg::REG_CORE_CFG;
    wire wr_seq   = wr_go && aw_addr_q == rsa_pkg::REG_SEQ_CFG;
    wire wr_int   = wr_go && aw_addr_q == rsa_pkg::REG_INT_LINES;
    wire wr_xs    = wr_go && aw_addr_q == rsa_pkg::REG_X_START;
    wire wr_ys    = wr_go && aw_addr_q == rsa_pkg::REG_Y_START;
    wire wr_nl    = wr_go && aw_addr_q == rsa_pkg::REG_NUM_LINES;
    wire wr_np    = wr_go && aw_addr_q == rsa_pkg::REG_NUM_PAIRS;
    wire wr_ro    = aw_addr_q == rsa_pkg::REG_ROW_STAT || aw_addr_q == rsa_pkg::REG_COL_STAT;
    wire wr_hit   = wr_core || wr_seq || wr_int || wr_xs || wr_ys || wr_nl || wr_np;

    wire [31:0] core_m = merge({27'h0, col_sub_q, 2'h0}, w_data_q, w_strb_q);
    wire [31:0] seq_m  = merge({20'h0, seq_cfg_q}, w_data_q, w_strb_q);
    wire [31:0] int_m  = merge({20'h0, int_lines_q}, w_data_q, w_strb_q);
    wire [31:0] xs_m   = merge({25'h0, x_start_q}, w_data_q, w_strb_q);
    wire [31:0] ys_m   = merge({24'h0, y_start_q}, w_data_q, w_strb_q);
    wire [31:0] nl_m   = merge({20'h0, num_lines_q}, w_data_q, w_strb_q);
    wire [31:0] np_m   = merge({21'h0, num_pairs_q}, w_data_q, w_strb_q);

    // Start coordinates limited to the valid range
    wire [6:0]  xs_new = (xs_m[6:0] > rsa_pkg::X_START_MAX) ? rsa_pkg::X_START_MAX : xs_m[6:0]; // RULE4
    wire [7:0]  ys_new = (ys_m[7:0] > rsa_pkg::Y_START_MAX) ? rsa_pkg::Y_START_MAX : ys_m[7:0]; // RULE4

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            col_sub_q   <= rsa_pkg::CORE_SUB_RST;
            seq_cfg_q   <= rsa_pkg::SEQ_CFG_RST;
            int_lines_q <= rsa_pkg::INT_LINES_RST;
            x_start_q   <= rsa_pkg::X_START_RST;
            y_start_q   <= rsa_pkg::Y_START_RST;
            num_lines_q <= rsa_pkg::NUM_LINES_RST;
            num_pairs_q <= rsa_pkg::NUM_PAIRS_RST;
        end else begin
            if (wr_core) col_sub_q <= core_m[rsa_pkg::SUB_MSB:rsa_pkg::SUB_LSB]; // RULE13
            if (wr_seq) seq_cfg_q <= seq_m[11:0];
            if (wr_int) int_lines_q <= int_m[11:0]; // RULE9
            if (wr_xs) x_start_q <= xs_new;
            if (wr_ys) y_start_q <= ys_new;
            if (wr_nl) num_lines_q <= nl_m[11:0];
            if (wr_np) num_pairs_q <= np_m[10:0];
        end
    end

    // Write channel handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= rsa_pkg::RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (wr_hit || wr_ro) ? rsa_pkg::RESP_OKAY : rsa_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Mode decode
    wire [3:0] col_step = step_of(col_sub_q);
    wire       ndr_on   = seq_cfg_q[rsa_pkg::NDR_BIT];
    wire [1:0] ndr_mode = seq_cfg_q[rsa_pkg::NDRM_MSB:rsa_pkg::NDRM_LSB];
    wire       both_bit = seq_cfg_q[rsa_pkg::BOTH_BIT]; // RULE16
    wire       merge_d  = both_bit || (ndr_on && (ndr_mode == 2'h1 || ndr_mode == 2'h2)); // RULE10

    // Row pointers
    logic [11:0] read_idx;
    logic [11:0] reset_idx;
    logic        frame_on_q;
    wire  [11:0] lead    = (int_lines_q < num_lines_q) ? int_lines_q : 12'h000; // RULE12
    wire         row_adv = row_clk && frame_on_q && !frame_start; // RULE8

    rsa_line_counter #(.W(12)) u_read_ptr ( // RULE7
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (frame_start), // RULE14
        .load_val (12'h000),
        .adv      (row_adv),
        .limit    (num_lines_q),
        .idx      (read_idx)
    );

    rsa_line_counter #(.W(12)) u_reset_ptr ( // RULE7
        .aclk     (aclk),
        .aresetn  (aresetn),
        .load     (frame_start),
        .load_val (lead), // RULE9 RULE12
        .adv      (row_adv),
        .limit    (num_lines_q),
        .idx      (reset_idx)
    );

    wire [15:0] read_row  = row_of(y_start_q, read_idx, col_step);
    wire [15:0] reset_row = row_of(y_start_q, reset_idx, col_step);

    // Row outputs
    rsa_pkg::rsa_row_s row_q;
    logic              read_pulse_q;
    logic              reset_pulse_q;
    logic              both_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            frame_on_q    <= 1'b0;
            row_q         <= '0;
            read_pulse_q  <= 1'b0;
            reset_pulse_q <= 1'b0;
            both_q        <= 1'b0;
        end else begin
            if (frame_start) frame_on_q <= 1'b1;
            both_q             <= merge_d;
            row_q.read_addr    <= read_row[11:0];
            // Merged registers drive the same row from both sides
            row_q.reset_addr   <= merge_d ? read_row[11:0] : reset_row[11:0]; // RULE10 RULE11
            read_pulse_q       <= row_clk && frame_on_q;
            reset_pulse_q      <= row_clk && frame_on_q; // RULE8 RULE11
        end
    end

    assign row_addr        = row_q;
    assign row_read_pulse  = read_pulse_q;
    assign row_reset_pulse = reset_pulse_q;
    assign both_sides      = both_q;

    // Column pair scan
    logic [10:0]      pair_cnt_q;
    logic             col_on_q;
    logic [COL_W-1:0] col_q;
    logic             col_valid_q;
    wire  [15:0]      col_base = 16'(x_start_q) * 16'(rsa_pkg::BLOCK_W); // RULE3 RULE4
    wire  [15:0]      col_next = 16'(col_base + 16'(pair_cnt_q) * 16'(col_step)); // RULE2 RULE5
    wire              col_last = (pair_cnt_q + 11'h001) >= num_pairs_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pair_cnt_q  <= 11'h000;
            col_on_q    <= 1'b0;
            col_q       <= '0;
            col_valid_q <= 1'b0;
        end else if (row_clk) begin
            pair_cnt_q  <= 11'h000; // RULE15
            col_on_q    <= num_pairs_q != 11'h000;
            col_valid_q <= 1'b0;
        end else if (pix_en && col_on_q) begin
            col_q       <= COL_W'(col_next); // RULE5
            col_valid_q <= 1'b1;
            pair_cnt_q  <= pair_cnt_q + 11'h001;
            col_on_q    <= !col_last;
        end else if (pix_en) begin
            col_valid_q <= 1'b0;
        end
    end

    assign col_pair_addr = col_q;
    assign col_valid     = col_valid_q;

    // Read decode
    wire [7:0]  ra     = {s_axi_araddr[7:2], 2'h0};
    wire [31:0] stat_r = {4'h0, row_q.reset_addr, 4'h0, row_q.read_addr};
    wire [31:0] stat_c = {frame_on_q, both_q, col_on_q, 1'b0, 16'h0000, col_q[11:0]};
    wire        rd_hit = ra <= rsa_pkg::REG_COL_STAT;
    wire [31:0] rd_val =
        (ra == rsa_pkg::REG_CORE_CFG)  ? {27'h0, col_sub_q, 2'h0} :
        (ra == rsa_pkg::REG_SEQ_CFG)   ? {20'h0, seq_cfg_q} :
        (ra == rsa_pkg::REG_INT_LINES) ? {20'h0, int_lines_q} :
        (ra == rsa_pkg::REG_X_START)   ? {25'h0, x_start_q} :
        (ra == rsa_pkg::REG_Y_START)   ? {24'h0, y_start_q} :
        (ra == rsa_pkg::REG_NUM_LINES) ? {20'h0, num_lines_q} :
        (ra == rsa_pkg::REG_NUM_PAIRS) ? {21'h0, num_pairs_q} :
        (ra == rsa_pkg::REG_ROW_STAT)  ? stat_r :
        (ra == rsa_pkg::REG_COL_STAT)  ? stat_c : 32'h0000_0000;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= rsa_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= rd_hit ? rsa_pkg::RESP_OKAY : rsa_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule : rsa_addressing

// [rsa_addressing_monitor.sv]
`timescale 1ns/100ps
module rsa_addressing_monitor #(
    parameter int COL_W = 12
) (
    // Clock and reset
    input wire logic              aclk,
    input wire logic              aresetn,
    // Controller pulses
    input wire logic              frame_start,
    input wire logic              row_clk,
    input wire logic              pix_en,
    // Addressing outputs
    input wire rsa_pkg::rsa_row_s row_addr,
    input wire logic              row_read_pulse,
    input wire logic              row_reset_pulse,
    input wire logic              both_sides,
    input wire logic [COL_W-1:0]  col_pair_addr,
    input wire logic              col_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Frame seen, and first pixel pair of a row still to come
    logic seen_q;
    logic fresh_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) seen_q <= 1'b0;
        else if (frame_start) seen_q <= 1'b1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) fresh_q <= 1'b0;
        else if (row_clk) fresh_q <= 1'b1;
        else if (pix_en) fresh_q <= 1'b0;
    end
    a_row_advance: assert property (row_clk && !frame_start && seen_q |=> row_read_pulse)
        else $error("row pulse missing after row clock");
    a_no_early_pulse: assert property (row_clk && !frame_start && !seen_q |=> !row_read_pulse)
        else $error("row pulse before any frame start");
    a_pulse_cause: assert property (!row_clk |=> !row_read_pulse)
        else $error("row pulse without row clock");
    a_pulses_paired: assert property (row_read_pulse == row_reset_pulse)
        else $error("read and reset pulses differ");
    a_col_clear: assert property (row_clk |=> !col_valid)
        else $error("pair still valid after row clock");
    a_col_hold: assert property (!pix_en && !row_clk |=> $stable(col_valid) && $stable(col_pair_addr))
        else $error("column pair changed without pixel enable");
    a_col_step: assert property (col_valid && pix_en && !row_clk
        |=> !col_valid || (col_pair_addr - $past(col_pair_addr)) inside {2, 4, 6, 8, 12})
        else $error("column pair step not a legal step");
    a_col_block: assert property (fresh_q && pix_en && !row_clk |=> !col_valid || col_pair_addr % 24 == 0)
        else $error("first column pair not on a block edge");
    a_row_block: assert property (frame_start ##1 !frame_start |=> row_addr.read_addr % 24 == 0)
        else $error("first row not on a block edge");
    a_both_equal: assert property (both_sides [*3] |-> row_addr.reset_addr == row_addr.read_addr)
        else $error("merged sides but pointers differ");
    c_row_advance: cover property (row_clk && seen_q);
    c_both_sides: cover property (both_sides [*3]);
    c_col_run: cover property (pix_en && col_valid);
endmodule : rsa_addressing_monitor

bind rsa_addressing rsa_addressing_monitor #(.COL_W(COL_W)) i_mon (
    .aclk(aclk), .aresetn(aresetn), .frame_start(frame_start), .row_clk(row_clk), .pix_en(pix_en),
    .row_addr(row_addr), .row_read_pulse(row_read_pulse), .row_reset_pulse(row_reset_pulse),
    .both_sides(both_sides), .col_pair_addr(col_pair_addr), .col_valid(col_valid)
);

// [rsa_addressing_tb.sv]
`timescale 1ns/100ps
module rsa_addressing_tb;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
    logic [7:0]        awaddr, araddr;
    logic [31:0]       wdata, rdata, rd;
    logic [1:0]        bresp, rresp, resp;
    logic              frame_start, row_clk, pix_en, row_read_pulse, row_reset_pulse, both_sides, col_valid;
    logic [11:0]       col_pair_addr;
    rsa_pkg::rsa_row_s row_addr;
    int                fails, n_checks;
    localparam logic [7:0]  RA [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
    localparam logic [31:0] RV [0:6] = '{32'h0, 32'h80, 32'h1, 32'h0, 32'h0, 32'hBC6, 32'h200};
    localparam int          CODES [0:5] = '{0, 1, 2, 3, 4, 7};
    localparam int          STEPS [0:5] = '{2, 4, 6, 8, 12, 12};
    localparam logic [31:0] SEQS [0:5] = '{32'h10, 32'h03, 32'h05, 32'h07, 32'h02, 32'h00};
    localparam logic        BOTH [0:5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

    rsa_addressing i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .frame_start(frame_start), .row_clk(row_clk),
        .pix_en(pix_en), .row_addr(row_addr), .row_read_pulse(row_read_pulse),
        .row_reset_pulse(row_reset_pulse), .both_sides(both_sides), .col_pair_addr(col_pair_addr),
        .col_valid(col_valid)
    );
    rsa_timing_ctrl i_ctrl (.aclk(aclk), .frame_start(frame_start), .row_clk(row_clk), .pix_en(pix_en));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : check

    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd   = rdata;
        resp = rresp;
    endtask : axi_read

    function automatic logic [31:0] row_of(input int y, input int i, input int st);
        return 32'(y * 24 + (i / 2) * st + i % 2);
    endfunction : row_of

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        tally_and_finish();
    end

    initial begin
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        arvalid = 1'b0;
        awaddr  = 8'h00;
        araddr  = 8'h00;
        wdata   = 32'h0;
        fails    = 0;
        n_checks = 0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values, unmapped place and start clamping
        for (int k = 0; k < 7; k++) begin
            axi_read(RA[k]);
            check("reset value", RV[k], rd);
        end
        axi_read(8'h40);
        check("unmapped read", 32'h0, rd);
        check("unmapped resp", 32'(rsa_pkg::RESP_SLVERR), 32'(resp));
        axi_write(8'h40, 32'h1);
        check("unmapped write", 32'(rsa_pkg::RESP_SLVERR), 32'(resp));
        axi_write(rsa_pkg::REG_ROW_STAT, 32'h1);
        check("status write", 32'(rsa_pkg::RESP_OKAY), 32'(resp));
        axi_write(rsa_pkg::REG_X_START, 32'h7F);
        axi_read(rsa_pkg::REG_X_START);
        check("column start clamp", 32'h62, rd);
        axi_write(rsa_pkg::REG_Y_START, 32'hFF);
        axi_read(rsa_pkg::REG_Y_START);
        check("row start clamp", 32'h89, rd);
        axi_write(rsa_pkg::REG_X_START, 32'h1);
        axi_write(rsa_pkg::REG_Y_START, 32'h2);
        i_ctrl.pulse(1, 0);
        #1 check("pulse before frame", 32'h0, 32'(row_read_pulse));
        $display("test registers done");
        // Rolling shutter over a short frame with wrap
        axi_write(rsa_pkg::REG_NUM_LINES, 32'h5);
        axi_write(rsa_pkg::REG_INT_LINES, 32'h3);
        axi_write(rsa_pkg::REG_CORE_CFG, 32'h4);
        i_ctrl.pulse(0, 0);
        for (int i = 0; i < 7; i++) begin
            @(posedge aclk);
            #1 check("read row", row_of(2, i % 5, 4), 32'(row_addr.read_addr));
            check("reset row", row_of(2, (i + 3) % 5, 4), 32'(row_addr.reset_addr));
            i_ctrl.pulse(1, i % 2);
            #1 check("row pulses", 32'h3, 32'({row_read_pulse, row_reset_pulse}));
        end
        $display("test shutter done");
        // Every pixel step, codes 0 to 4 and 7, pair limit reached
        axi_write(rsa_pkg::REG_NUM_PAIRS, 32'h3);
        for (int m = 0; m < 6; m++) begin
            axi_write(rsa_pkg::REG_CORE_CFG, 32'(CODES[m]) << 2);
            i_ctrl.pulse(1, 0);
            for (int k = 0; k < 4; k++) begin
                i_ctrl.pulse(2, 0);
                #1 check("pair valid", 32'(k < 3), 32'(col_valid));
                if (k < 3) check("pair column", 32'(24 + k * STEPS[m]), 32'(col_pair_addr));
            end
        end
        $display("test subsampling done");
        // Both-side addressing and readout modes
        for (int s = 0; s < 6; s++) begin
            axi_write(rsa_pkg::REG_SEQ_CFG, SEQS[s]);
            i_ctrl.pulse(0, 1);
            @(posedge aclk);
            #1 check("both sides", 32'(BOTH[s]), 32'(both_sides));
            check("reset row side", BOTH[s] ? 32'd48 : 32'd61, 32'(row_addr.reset_addr));
        end
        axi_read(rsa_pkg::REG_ROW_STAT);
        check("row status", 32'h003D_0030, rd);
        $display("test both sides done");
        tally_and_finish();
    end
endmodule : rsa_addressing_tb

// [rsa_line_counter.sv]
`timescale 1ns/100ps
module rsa_line_counter #(
    parameter int W = 12
) (
    // Clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         adv,
    input  wire logic [W-1:0] limit,
    // Line index
    output logic      [W-1:0] idx
);

    logic [W-1:0] idx_q;
    logic [W-1:0] idx_d;
    logic [W-1:0] idx_inc;

    assign idx_inc = idx_q + {{(W-1){1'b0}}, 1'b1};
    // Wrap within the frame line range
    assign idx_d   = load ? load_val : (adv ? ((idx_inc >= limit) ? '0 : idx_inc) : idx_q);
    assign idx     = idx_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idx_q <= '0;
        end else begin
            idx_q <= idx_d;
        end
    end

endmodule : rsa_line_counter

// [rsa_pkg.sv]
package rsa_pkg;

    // Register byte offsets
    localparam logic [7:0] REG_CORE_CFG  = 8'h00;
    localparam logic [7:0] REG_SEQ_CFG   = 8'h04;
    localparam logic [7:0] REG_INT_LINES = 8'h08;
    localparam logic [7:0] REG_X_START   = 8'h0C;
    localparam logic [7:0] REG_Y_START   = 8'h10;
    localparam logic [7:0] REG_NUM_LINES = 8'h14;
    localparam logic [7:0] REG_NUM_PAIRS = 8'h18;
    localparam logic [7:0] REG_ROW_STAT  = 8'h1C;
    localparam logic [7:0] REG_COL_STAT  = 8'h20;

    // Field positions
    localparam int SUB_LSB    = 2;
    localparam int SUB_MSB    = 4;
    localparam int NDR_BIT    = 0;
    localparam int NDRM_LSB   = 1;
    localparam int NDRM_MSB   = 2;
    localparam int BOTH_BIT   = 4;

    // Values after reset
    localparam logic [2:0]  CORE_SUB_RST  = 3'h0;
    localparam logic [11:0] SEQ_CFG_RST   = 12'h080;
    localparam logic [11:0] INT_LINES_RST = 12'h001;
    localparam logic [6:0]  X_START_RST   = 7'h00;
    localparam logic [7:0]  Y_START_RST   = 8'h00;
    localparam logic [11:0] NUM_LINES_RST = 12'hBC6;
    localparam logic [10:0] NUM_PAIRS_RST = 11'h200;

    // Addressing geometry
    localparam logic [4:0]  BLOCK_W       = 5'h18;
    localparam logic [6:0]  X_START_MAX   = 7'h62;
    localparam logic [7:0]  Y_START_MAX   = 8'h89;
    localparam logic [3:0]  STEP_A        = 4'h2;
    localparam logic [3:0]  STEP_B        = 4'h4;
    localparam logic [3:0]  STEP_C        = 4'h6;
    localparam logic [3:0]  STEP_D        = 4'h8;
    localparam logic [3:0]  STEP_E        = 4'hC;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic [11:0] read_addr;
        logic [11:0] reset_addr;
    } rsa_row_s;

endpackage : rsa_pkg

// [rsa_timing_ctrl.sv]
`timescale 1ns/100ps
module rsa_timing_ctrl (
    // Clock
    input wire logic aclk,
    // Pulses to the addressing block
    output logic     frame_start,
    output logic     row_clk,
    output logic     pix_en
);
    initial begin
        frame_start = 1'b0;
        row_clk     = 1'b0;
        pix_en      = 1'b0;
    end
    // Kind 0 frame start, 1 row clock, 2 pixel pair; gap idle cycles first
    task automatic pulse(input int kind, input int gap);
        repeat (gap + 1) @(posedge aclk);
        if (kind == 0) frame_start <= 1'b1;
        else if (kind == 1) row_clk <= 1'b1;
        else pix_en <= 1'b1;
        @(posedge aclk);
        frame_start <= 1'b0;
        row_clk     <= 1'b0;
        pix_en      <= 1'b0;
    endtask : pulse
endmodule : rsa_timing_ctrl
